// >>> inc/rvic_pkg.sv
package rvic_pkg;

	// ==========================================================
	// sizes
	localparam int          NUM_SRC       = 16;
	localparam int          NUM_TRAP      = 8;
	localparam int          NUM_EXT       = 3;
	localparam int          PRIO_W        = 3;
	localparam int          LVL_W         = 4;
	localparam int          VEC_W         = 8;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          PC_W          = 24;
	localparam int          PRIO_PER_REG  = 4;
	localparam int          PRIO_STRIDE   = 4;
	localparam int          NUM_PRIO_REG  = NUM_SRC / PRIO_PER_REG;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_CTRL1   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL2   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CTRL3   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CTRL4   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_FLAGS   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ENABLES = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PRIO0   = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_PEND    = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_CORE    = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_RCC     = 8'h34;
	localparam logic [ADDR_W-1:0] OFF_EVT     = 8'h38;
	localparam logic [ADDR_W-1:0] OFF_EVT_MSK = 8'h3c;
	localparam logic [ADDR_W-1:0] PRIO_STEP   = 8'h04;

	// ==========================================================
	// field positions
	localparam int BIT_NEST_DIS   = 15;
	localparam int BIT_ADDR_ERR   = 3;
	localparam int BIT_STK_ERR    = 2;
	localparam int BIT_OSC_FAIL   = 1;
	localparam int BIT_GIE        = 15;
	localparam int BIT_DEADMAN    = 2;
	localparam int BIT_DMA_ERR    = 1;
	localparam int BIT_DO_OVF     = 0;
	localparam int BIT_ECC_DBE    = 1;
	localparam int BIT_SW_TRAP    = 0;
	localparam int BIT_IPL_LO     = 5;
	localparam int BIT_IPL_TOP    = 3;
	localparam int BIT_SOFT_WDT   = 5;
	localparam int BIT_LVL_LO     = 8;
	localparam int NUM_EVT        = 2;
	localparam int EVT_TRAP       = 0;
	localparam int EVT_TAKEN      = 1;

	// ==========================================================
	// trap source indices, highest trap level first
	localparam int TRAP_OSC_FAIL  = 0;
	localparam int TRAP_ADDR_ERR  = 1;
	localparam int TRAP_STK_ERR   = 2;
	localparam int TRAP_DMA_ERR   = 3;
	localparam int TRAP_DO_OVF    = 4;
	localparam int TRAP_DEADMAN   = 5;
	localparam int TRAP_ECC_DBE   = 6;
	localparam int TRAP_SW_TRAP   = 7;

	// ==========================================================
	// levels, vectors, reset values
	localparam logic [LVL_W-1:0]  TRAP_LVL_TOP   = 4'hf;
	localparam logic [LVL_W-1:0]  USER_LVL_MAX   = 4'h7;
	localparam logic [VEC_W-1:0]  TRAP_VEC_BASE  = 8'h00;
	localparam logic [VEC_W-1:0]  USER_VEC_BASE  = 8'h08;
	localparam logic [PC_W-1:0]   RESET_ADDR     = 24'h000000;
	localparam logic [1:0]        FUSE_UNPROG    = 2'h3;
	localparam logic [DATA_W-1:0] DATA_ZERO      = 32'h00000000;

	typedef enum logic [1:0] {
		RV_RESET = 2'b00,
		RV_START = 2'b01,
		RV_RUN   = 2'b10
	} rvic_phase_type;

endpackage : rvic_pkg

// >>> core/rvic_arbiter.sv
`timescale 1ns/1ps
module rvic_arbiter
	import rvic_pkg::*;
(
	input  wire logic [rvic_pkg::NUM_SRC-1:0]                  flags_i,
	input  wire logic [rvic_pkg::NUM_SRC-1:0]                  enables_i,
	input  wire logic [rvic_pkg::NUM_SRC*rvic_pkg::PRIO_W-1:0] prios_i,
	input  wire logic [rvic_pkg::NUM_TRAP-1:0]                 traps_i,
	input  wire logic [rvic_pkg::LVL_W-1:0]                    cpu_lvl_i,
	input  wire logic                                          gie_i,
	output logic                                               valid_o,
	output logic      [rvic_pkg::VEC_W-1:0]                    vec_o,
	output logic      [rvic_pkg::LVL_W-1:0]                    lvl_o
);
	import rvic_pkg::*;

	logic [LVL_W-1:0] best;
	logic [LVL_W-1:0] cand;

	always_comb begin
		best    = cpu_lvl_i;
		cand    = '0;
		valid_o = 1'b0;
		vec_o   = '0;
		for (int t = 0; t < NUM_TRAP; t++) begin
			cand = TRAP_LVL_TOP - LVL_W'(t);
			if (traps_i[t] && cand > best) begin
				best    = cand;
				valid_o = 1'b1;
				vec_o   = TRAP_VEC_BASE + VEC_W'(t);
			end
		end
		// strict compare, lowest vector wins ties
		for (int s = 0; s < NUM_SRC; s++) begin
			cand = {1'b0, prios_i[s*PRIO_W +: PRIO_W]};
			if (gie_i && flags_i[s] && enables_i[s] && cand > best) begin
				best    = cand;
				valid_o = 1'b1;
				vec_o   = USER_VEC_BASE + VEC_W'(s);
			end
		end
		lvl_o = best;
	end

endmodule : rvic_arbiter

// >>> core/rvic_top.sv
`timescale 1ns/1ps
module rvic_top
	import rvic_pkg::*;
(
	input  wire logic                          CORE_CLK_I,
	input  wire logic                          RST_I,
	input  wire logic                          PSEL_I,
	input  wire logic                          PENABLE_I,
	input  wire logic                          PWRITE_I,
	input  wire logic [rvic_pkg::ADDR_W-1:0]   PADDR_I,
	input  wire logic [rvic_pkg::DATA_W-1:0]   PWDATA_I,
	output logic      [rvic_pkg::DATA_W-1:0]   PRDATA_O,
	output logic                               PREADY_O,
	output logic                               PSLVERR_O,
	input  wire logic [rvic_pkg::NUM_SRC-1:0]  SRC_REQ_I,
	input  wire logic [rvic_pkg::NUM_EXT-1:0]  EXT_PIN_I,
	input  wire logic [rvic_pkg::NUM_TRAP-1:0] TRAP_EVT_I,
	input  wire logic [1:0]                    WDT_FUSE_I,
	input  wire logic                          ACK_I,
	input  wire logic                          RETURN_I,
	input  wire logic [rvic_pkg::LVL_W-1:0]    RET_LVL_I,
	output logic                               IRQ_REQ_O,
	output logic      [rvic_pkg::VEC_W-1:0]    VECTOR_O,
	output logic      [rvic_pkg::LVL_W-1:0]    NEW_LVL_O,
	output logic      [rvic_pkg::LVL_W-1:0]    CPU_LVL_O,
	output logic                               CORE_START_O,
	output logic      [rvic_pkg::PC_W-1:0]     RESET_PC_O,
	output logic                               WDT_EN_O,
	output logic                               IRQ_O
);
	import rvic_pkg::*;

	// ==========================================================
	// decode helpers
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic prio_hit(input logic [ADDR_W-1:0] a, input int r);
		prio_hit = (a == OFF_PRIO0 + ADDR_W'(r) * PRIO_STEP);
	endfunction : prio_hit

	// ==========================================================
	// state
	rvic_phase_type                phase_q, phase_d;
	logic                          nest_dis_q, nest_dis_d;
	logic [NUM_TRAP-1:0]           trap_q, trap_d;
	logic                          gie_q, gie_d;
	logic [NUM_EXT-1:0]            ext_neg_q, ext_neg_d;
	logic [NUM_EXT-1:0]            ext_prev_q, ext_prev_d;
	logic [NUM_SRC-1:0]            flag_q, flag_d;
	logic [NUM_SRC-1:0]            en_q, en_d;
	logic [NUM_SRC*PRIO_W-1:0]     prio_q, prio_d;
	logic [VEC_W-1:0]              vec_q, vec_d;
	logic [LVL_W-1:0]              lvl_q, lvl_d;
	logic [PRIO_W-1:0]             ipl_lo_q, ipl_lo_d;
	logic                          ipl_top_q, ipl_top_d;
	logic                          soft_wdt_q, soft_wdt_d;
	logic                          wdt_en_q, wdt_en_d;
	logic [NUM_EVT-1:0]            evt_q, evt_d;
	logic [NUM_EVT-1:0]            msk_q, msk_d;
	logic [DATA_W-1:0]             rdata_q, rdata_d;
	logic                          err_q, err_d;

	logic                          wr_en;
	logic                          setup;
	logic [NUM_SRC-1:0]            src_set;
	logic [NUM_EXT-1:0]            ext_edge;
	logic [LVL_W-1:0]              cpu_lvl;
	logic                          arb_valid;
	logic [VEC_W-1:0]              arb_vec;
	logic [LVL_W-1:0]              arb_lvl;
	logic                          run;
	logic                          take;
	logic [DATA_W-1:0]             rd_val;
	logic                          rd_ok;

	assign wr_en   = PSEL_I & PENABLE_I & PWRITE_I;
	assign setup   = PSEL_I & ~PENABLE_I;
	assign cpu_lvl = {ipl_top_q, ipl_lo_q};
	// arbitration held off until the cycle after the core start pulse
	assign run     = (phase_q == RV_RUN);
	assign take    = run & ACK_I & arb_valid;

	// ==========================================================
	// external pins: edge detect with selectable polarity
	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g++) begin : g_ext
			// polarity bit selects falling instead of rising edge
			assign ext_edge[g] = ext_neg_q[g] ? (ext_prev_q[g] & ~EXT_PIN_I[g])
				: (~ext_prev_q[g] & EXT_PIN_I[g]);
		end
	endgenerate

	// pins land on the lowest source positions, vector order
	assign src_set = SRC_REQ_I | {{(NUM_SRC-NUM_EXT){1'b0}}, ext_edge};

	// ==========================================================
	// arbitration
	rvic_arbiter u_arb (
		.flags_i   (flag_q),
		.enables_i (en_q),
		.prios_i   (prio_q),
		.traps_i   (trap_q),
		.cpu_lvl_i (cpu_lvl),
		.gie_i     (gie_q),
		.valid_o   (arb_valid),
		.vec_o     (arb_vec),
		.lvl_o     (arb_lvl)
	);

	// ==========================================================
	// read mux
	always_comb begin
		rd_val = DATA_ZERO;
		rd_ok  = 1'b1;
		if (hit(PADDR_I, OFF_CTRL1)) begin
			rd_val[BIT_NEST_DIS] = nest_dis_q;
			// address error flag at bit 3
			rd_val[BIT_ADDR_ERR] = trap_q[TRAP_ADDR_ERR];
			rd_val[BIT_STK_ERR]  = trap_q[TRAP_STK_ERR];
			rd_val[BIT_OSC_FAIL] = trap_q[TRAP_OSC_FAIL];
		end else if (hit(PADDR_I, OFF_CTRL2)) begin
			rd_val[BIT_GIE]       = gie_q;
			rd_val[NUM_EXT-1:0]   = ext_neg_q;
		end else if (hit(PADDR_I, OFF_CTRL3)) begin
			rd_val[BIT_DEADMAN] = trap_q[TRAP_DEADMAN];
			rd_val[BIT_DMA_ERR] = trap_q[TRAP_DMA_ERR];
			rd_val[BIT_DO_OVF]  = trap_q[TRAP_DO_OVF];
		end else if (hit(PADDR_I, OFF_CTRL4)) begin
			rd_val[BIT_ECC_DBE] = trap_q[TRAP_ECC_DBE];
			rd_val[BIT_SW_TRAP] = trap_q[TRAP_SW_TRAP];
		end else if (hit(PADDR_I, OFF_FLAGS)) begin
			rd_val[NUM_SRC-1:0] = flag_q;
		end else if (hit(PADDR_I, OFF_ENABLES)) begin
			rd_val[NUM_SRC-1:0] = en_q;
		end else if (hit(PADDR_I, OFF_PEND)) begin
			rd_val[VEC_W-1:0]                  = vec_q;
			rd_val[BIT_LVL_LO +: LVL_W]        = lvl_q;
		end else if (hit(PADDR_I, OFF_STATUS)) begin
			rd_val[BIT_IPL_LO +: PRIO_W] = ipl_lo_q;
		end else if (hit(PADDR_I, OFF_CORE)) begin
			rd_val[BIT_IPL_TOP] = ipl_top_q;
		end else if (hit(PADDR_I, OFF_RCC)) begin
			rd_val[BIT_SOFT_WDT] = soft_wdt_q;
		end else if (hit(PADDR_I, OFF_EVT)) begin
			rd_val[NUM_EVT-1:0] = evt_q;
		end else if (hit(PADDR_I, OFF_EVT_MSK)) begin
			rd_val[NUM_EVT-1:0] = msk_q;
		end else begin
			rd_ok = 1'b0;
			for (int r = 0; r < NUM_PRIO_REG; r++) begin
				if (prio_hit(PADDR_I, r)) begin
					rd_ok = 1'b1;
					for (int k = 0; k < PRIO_PER_REG; k++) begin
						rd_val[k*PRIO_STRIDE +: PRIO_W] =
							prio_q[(r*PRIO_PER_REG+k)*PRIO_W +: PRIO_W];
					end
				end
			end
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		phase_d    = phase_q;
		nest_dis_d = nest_dis_q;
		gie_d      = gie_q;
		ext_neg_d  = ext_neg_q;
		ext_prev_d = EXT_PIN_I;
		en_d       = en_q;
		prio_d     = prio_q;
		ipl_lo_d   = ipl_lo_q;
		ipl_top_d  = ipl_top_q;
		soft_wdt_d = soft_wdt_q;
		msk_d      = msk_q;
		vec_d      = vec_q;
		lvl_d      = lvl_q;
		rdata_d    = rdata_q;
		err_d      = err_q;
		trap_d     = trap_q;
		flag_d     = flag_q;
		evt_d      = evt_q;

		// core released from the cleared state at the reset address
		case (phase_q)
			RV_RESET: phase_d = RV_START;
			RV_START: phase_d = RV_RUN;
			RV_RUN:   phase_d = RV_RUN;
			default:  phase_d = RV_RESET;
		endcase

		// read data captured in setup so it comes from flops in the access phase
		if (setup) begin
			rdata_d = PWRITE_I ? DATA_ZERO : rd_val;
			err_d   = ~rd_ok;
		end

		// software clears status flags by writing one; control fields are written directly
		if (wr_en && rd_ok) begin
			if (hit(PADDR_I, OFF_CTRL1)) begin
				// nesting disable and processor trap flags
				nest_dis_d                = PWDATA_I[BIT_NEST_DIS];
				trap_d[TRAP_ADDR_ERR]     = trap_q[TRAP_ADDR_ERR] & ~PWDATA_I[BIT_ADDR_ERR];
				trap_d[TRAP_STK_ERR]      = trap_q[TRAP_STK_ERR] & ~PWDATA_I[BIT_STK_ERR];
				trap_d[TRAP_OSC_FAIL]     = trap_q[TRAP_OSC_FAIL] & ~PWDATA_I[BIT_OSC_FAIL];
			end else if (hit(PADDR_I, OFF_CTRL2)) begin
				gie_d     = PWDATA_I[BIT_GIE];
				ext_neg_d = PWDATA_I[NUM_EXT-1:0];
			end else if (hit(PADDR_I, OFF_CTRL3)) begin
				// deadman, DMA and loop stack flags
				trap_d[TRAP_DEADMAN] = trap_q[TRAP_DEADMAN] & ~PWDATA_I[BIT_DEADMAN];
				trap_d[TRAP_DMA_ERR] = trap_q[TRAP_DMA_ERR] & ~PWDATA_I[BIT_DMA_ERR];
				trap_d[TRAP_DO_OVF]  = trap_q[TRAP_DO_OVF] & ~PWDATA_I[BIT_DO_OVF];
			end else if (hit(PADDR_I, OFF_CTRL4)) begin
				// ECC double error and software trap flags
				trap_d[TRAP_ECC_DBE] = trap_q[TRAP_ECC_DBE] & ~PWDATA_I[BIT_ECC_DBE];
				trap_d[TRAP_SW_TRAP] = trap_q[TRAP_SW_TRAP] & ~PWDATA_I[BIT_SW_TRAP];
			end else if (hit(PADDR_I, OFF_FLAGS)) begin
				flag_d = flag_q & ~PWDATA_I[NUM_SRC-1:0];
			end else if (hit(PADDR_I, OFF_ENABLES)) begin
				en_d = PWDATA_I[NUM_SRC-1:0];
			end else if (hit(PADDR_I, OFF_STATUS)) begin
				// software sets the low level bits
				ipl_lo_d = PWDATA_I[BIT_IPL_LO +: PRIO_W];
			end else if (hit(PADDR_I, OFF_RCC)) begin
				soft_wdt_d = PWDATA_I[BIT_SOFT_WDT];
			end else if (hit(PADDR_I, OFF_EVT)) begin
				evt_d = evt_q & ~PWDATA_I[NUM_EVT-1:0];
			end else if (hit(PADDR_I, OFF_EVT_MSK)) begin
				msk_d = PWDATA_I[NUM_EVT-1:0];
			end else begin
				for (int r = 0; r < NUM_PRIO_REG; r++) begin
					if (prio_hit(PADDR_I, r)) begin
						for (int k = 0; k < PRIO_PER_REG; k++) begin
							prio_d[(r*PRIO_PER_REG+k)*PRIO_W +: PRIO_W] =
								PWDATA_I[k*PRIO_STRIDE +: PRIO_W];
						end
					end
				end
			end
		end

		// hardware set applied after the clear so it wins
		flag_d = flag_d | src_set;
		trap_d = trap_d | TRAP_EVT_I;
		evt_d[EVT_TRAP]  = evt_d[EVT_TRAP] | (|TRAP_EVT_I);
		evt_d[EVT_TAKEN] = evt_d[EVT_TAKEN] | take;

		// latch the winner's vector and its priority
		if (run && arb_valid) begin
			vec_d = arb_vec;
			lvl_d = arb_lvl;
		end

		// core takes the request: raise level; nesting disable pins users at max
		if (take) begin
			if (nest_dis_q && !arb_lvl[LVL_W-1]) begin
				ipl_lo_d = USER_LVL_MAX[PRIO_W-1:0];
			end else begin
				ipl_lo_d = arb_lvl[PRIO_W-1:0];
			end
			// top bit only moves by hardware
			ipl_top_d = arb_lvl[LVL_W-1];
		end else if (RETURN_I) begin
			ipl_lo_d  = RET_LVL_I[PRIO_W-1:0];
			ipl_top_d = RET_LVL_I[LVL_W-1];
		end

		// unprogrammed fuse overrides the soft enable
		wdt_en_d = (WDT_FUSE_I == FUSE_UNPROG) | soft_wdt_q;
	end

	// ==========================================================
	// registers
	// every register cleared by reset
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			phase_q    <= RV_RESET;
			nest_dis_q <= 1'b0;
			trap_q     <= '0;
			gie_q      <= 1'b0;
			ext_neg_q  <= '0;
			ext_prev_q <= '0;
			flag_q     <= '0;
			en_q       <= '0;
			prio_q     <= '0;
			vec_q      <= '0;
			lvl_q      <= '0;
			ipl_lo_q   <= '0;
			ipl_top_q  <= 1'b0;
			soft_wdt_q <= 1'b0;
			wdt_en_q   <= 1'b0;
			evt_q      <= '0;
			msk_q      <= '0;
			rdata_q    <= '0;
			err_q      <= 1'b0;
		end else begin
			phase_q    <= phase_d;
			nest_dis_q <= nest_dis_d;
			trap_q     <= trap_d;
			gie_q      <= gie_d;
			ext_neg_q  <= ext_neg_d;
			ext_prev_q <= ext_prev_d;
			flag_q     <= flag_d;
			en_q       <= en_d;
			prio_q     <= prio_d;
			vec_q      <= vec_d;
			lvl_q      <= lvl_d;
			ipl_lo_q   <= ipl_lo_d;
			ipl_top_q  <= ipl_top_d;
			soft_wdt_q <= soft_wdt_d;
			wdt_en_q   <= wdt_en_d;
			evt_q      <= evt_d;
			msk_q      <= msk_d;
			rdata_q    <= rdata_d;
			err_q      <= err_d;
		end
	end

	// ==========================================================
	// outputs
	assign PRDATA_O     = rdata_q;
	assign PREADY_O     = PSEL_I & PENABLE_I;
	assign PSLVERR_O    = PSEL_I & PENABLE_I & err_q;
	assign IRQ_REQ_O    = run & arb_valid;
	assign VECTOR_O     = vec_q;
	assign NEW_LVL_O    = lvl_q;
	assign CPU_LVL_O    = cpu_lvl;
	assign CORE_START_O = (phase_q == RV_START);
	assign RESET_PC_O   = RESET_ADDR;
	assign WDT_EN_O     = wdt_en_q;
	assign IRQ_O        = |(evt_q & msk_q);

endmodule : rvic_top

// >>> tb/rvic_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// core stand-in: takes a request, returns after a short or long handler
module rvic_core_model
	import rvic_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             irq_req_i,
	input  wire logic [LVL_W-1:0] cpu_lvl_i,
	input  wire logic             slow_i,
	output logic                  ack_o,
	output logic                  ret_o,
	output logic      [LVL_W-1:0] ret_lvl_o
);
	logic       busy_q;
	logic [3:0] cnt_q;
	// flags are left for software to clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{ack_o, ret_o, busy_q, cnt_q, ret_lvl_o} <= '0;
		end else begin
			ack_o <= 1'b0;
			ret_o <= 1'b0;
			if (!busy_q && irq_req_i) begin
				ack_o     <= 1'b1;
				busy_q    <= 1'b1;
				ret_lvl_o <= cpu_lvl_i;
				cnt_q     <= slow_i ? 4'h8 : 4'h1;
			end else if (busy_q && cnt_q == 4'h0) begin
				// level saved at entry is restored
				ret_o  <= 1'b1;
				busy_q <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule : rvic_core_model

// >>> tb/rvic_top_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module rvic_top_assertions
	import rvic_pkg::*;
(
	input wire logic             CORE_CLK_I,
	input wire logic             RST_I,
	input wire logic [1:0]       WDT_FUSE_I,
	input wire logic             ACK_I,
	input wire logic             RETURN_I,
	input wire logic             IRQ_REQ_O,
	input wire logic [VEC_W-1:0] VECTOR_O,
	input wire logic [LVL_W-1:0] NEW_LVL_O,
	input wire logic [LVL_W-1:0] CPU_LVL_O,
	input wire logic             CORE_START_O,
	input wire logic [PC_W-1:0]  RESET_PC_O,
	input wire logic             WDT_EN_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	a_wdt_forced_on: assert property (WDT_FUSE_I == FUSE_UNPROG |=> WDT_EN_O)
		else $error("watchdog not forced on");
	a_reset_pc_zero: assert property (RESET_PC_O == RESET_ADDR)
		else $error("reset address not zero");
	a_start_one_pulse: assert property (CORE_START_O |=> !CORE_START_O)
		else $error("start pulse too long");
	a_start_no_req: assert property (CORE_START_O |-> !IRQ_REQ_O)
		else $error("request during start");
	a_top_bit_ro: assert property ($changed(CPU_LVL_O[3]) |-> $past(ACK_I) || $past(RETURN_I))
		else $error("top level bit changed without core event");
	a_req_above_lvl: assert property (IRQ_REQ_O |=> NEW_LVL_O > $past(CPU_LVL_O))
		else $error("request not above cpu level");
	a_ack_raises_lvl: assert property (ACK_I && IRQ_REQ_O |=> CPU_LVL_O > $past(CPU_LVL_O))
		else $error("level not raised on take");
	a_trap_vec_lvl: assert property (NEW_LVL_O > USER_LVL_MAX |->
		VECTOR_O == {4'h0, TRAP_LVL_TOP - NEW_LVL_O})
		else $error("trap vector and level disagree");
	a_user_vec_range: assert property (NEW_LVL_O != 4'h0 && NEW_LVL_O <= USER_LVL_MAX |->
		VECTOR_O >= USER_VEC_BASE && VECTOR_O < USER_VEC_BASE + NUM_SRC)
		else $error("user vector out of range");
endmodule : rvic_top_assertions

bind rvic_top rvic_top_assertions u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
	.WDT_FUSE_I(WDT_FUSE_I), .ACK_I(ACK_I), .RETURN_I(RETURN_I), .IRQ_REQ_O(IRQ_REQ_O),
	.VECTOR_O(VECTOR_O), .NEW_LVL_O(NEW_LVL_O), .CPU_LVL_O(CPU_LVL_O),
	.CORE_START_O(CORE_START_O), .RESET_PC_O(RESET_PC_O), .WDT_EN_O(WDT_EN_O));

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench
module tb_top;
	import rvic_pkg::*;
	logic                clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, slow = 0;
	logic [ADDR_W-1:0]   padr = '0;
	logic [DATA_W-1:0]   pwd = '0, w;
	logic [NUM_SRC-1:0]  src = '0, m;
	logic [NUM_EXT-1:0]  pin = '0;
	logic [NUM_TRAP-1:0] trap = '0;
	logic [1:0]          fuse = '0;
	logic                ack, ret, pready, pslverr, irq_req, start, wdt_en, irq;
	logic [LVL_W-1:0]    ret_lvl, new_lvl, cpu_lvl;
	logic [DATA_W-1:0]   prdata;
	logic [VEC_W-1:0]    vec;
	logic [PC_W-1:0]     rpc;
	logic [32:0]         e, exp_q[$];
	logic [2:0]          pr[NUM_SRC];
	logic [ADDR_W-1:0]   toff[8] = '{OFF_CTRL1, OFF_CTRL1, OFF_CTRL1, OFF_CTRL3, OFF_CTRL3,
		OFF_CTRL3, OFF_CTRL4, OFF_CTRL4};
	int                  tbit[8] = '{BIT_OSC_FAIL, BIT_ADDR_ERR, BIT_STK_ERR, BIT_DMA_ERR,
		BIT_DO_OVF, BIT_DEADMAN, BIT_ECC_DBE, BIT_SW_TRAP};
	int                  fail_count = 0, num_checks = 0, cyc = 0, best;

	always #4 clk = ~clk;

	rvic_top DUT (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .SRC_REQ_I(src), .EXT_PIN_I(pin),
		.TRAP_EVT_I(trap), .WDT_FUSE_I(fuse), .ACK_I(ack), .RETURN_I(ret),
		.RET_LVL_I(ret_lvl), .IRQ_REQ_O(irq_req), .VECTOR_O(vec), .NEW_LVL_O(new_lvl),
		.CPU_LVL_O(cpu_lvl), .CORE_START_O(start), .RESET_PC_O(rpc), .WDT_EN_O(wdt_en),
		.IRQ_O(irq));
	rvic_core_model u_core (.clk_i(clk), .rst_i(rst), .irq_req_i(irq_req),
		.cpu_lvl_i(cpu_lvl), .slow_i(slow), .ack_o(ack), .ret_o(ret), .ret_lvl_o(ret_lvl));

	task chk(input string nm, input logic [DATA_W-1:0] ex, input logic [DATA_W-1:0] got);
		num_checks++;
		if (got !== ex) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task finish_test;
		if (fail_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test

	// reads note {slverr, data} as the expected answer
	task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic err);
		@(posedge clk);
		psel <= 1'b1; pen <= 1'b0; pwr <= wr; padr <= a; pwd <= d;
		if (!wr) exp_q.push_back({err, d});
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0; pen <= 1'b0;
	endtask : apb

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
		if (psel && pen && pready === 1'b1 && !pwr) begin
			e = exp_q.pop_front();
			chk("prdata", e[31:0], prdata);
			chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
		end
	end

	initial begin
		void'($urandom(94770));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 16; i++) apb(0, 8'(4 * i), DATA_ZERO, 0);
		apb(0, 8'hfc, DATA_ZERO, 1);
		#1 chk("reset pc", RESET_ADDR, rpc);
		repeat (2) @(posedge clk);
		#1 chk("wdt off", 0, wdt_en);
		apb(1, OFF_RCC, 32'h20, 0);
		// enable is registered from the soft bit, so it follows one edge after the write
		@(posedge clk);
		fuse <= 2'h3;
		#1 chk("wdt soft", 1, wdt_en);
		apb(1, OFF_RCC, 32'h0, 0);
		@(posedge clk);
		#1 chk("wdt fuse", 1, wdt_en);
		apb(1, OFF_CTRL1, 32'h8000, 0);
		apb(0, OFF_CTRL1, 32'h8000, 0);
		apb(1, OFF_CORE, 32'h8, 0);
		apb(0, OFF_CORE, 32'h0, 0);
		apb(1, OFF_CTRL2, 32'h8002, 0);
		pin <= 3'b011;
		repeat (2) @(posedge clk);
		pin <= 3'b001;
		apb(0, OFF_FLAGS, 32'h3, 0);
		apb(1, OFF_FLAGS, 32'hffff, 0);
		apb(0, OFF_FLAGS, 32'h0, 0);
		apb(1, OFF_ENABLES, 32'hffff, 0);
		apb(0, OFF_ENABLES, 32'hffff, 0);
		for (int k = 0; k < 6; k++) begin
			slow <= k[0];
			foreach (pr[s]) pr[s] = 3'($urandom_range(7, 1));
			for (int r = 0; r < 4; r++) begin
				w = '0;
				for (int j = 0; j < 4; j++) w[4*j +: 3] = pr[4*r+j];
				apb(1, OFF_PRIO0 + PRIO_STEP * 8'(r), w, 0);
			end
			m = 16'($urandom_range(65535, 1));
			src <= m;
			@(posedge clk);
			src <= '0;
			best = -1;
			foreach (pr[s]) if (m[s] && (best < 0 || pr[s] > pr[best])) best = s;
			repeat (3) @(posedge clk);
			#1 chk("vector", USER_VEC_BASE + best, vec);
			chk("new level", pr[best], new_lvl);
			apb(0, OFF_PEND, {21'h0, pr[best], 8'(USER_VEC_BASE + best)}, 0);
			apb(0, OFF_FLAGS, m, 0);
			apb(1, OFF_FLAGS, 32'hffff, 0);
			repeat (12) @(posedge clk);
		end
		apb(1, OFF_STATUS, 32'hff, 0);
		apb(0, OFF_STATUS, 32'he0, 0);
		src <= 16'h0001;
		@(posedge clk);
		src <= '0;
		repeat (3) @(posedge clk);
		#1 chk("masked request", 0, irq_req);
		chk("cpu level", 7, cpu_lvl);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			trap <= 8'(1 << i);
			@(posedge clk);
			trap <= '0;
			repeat (3) @(posedge clk);
			#1 chk("trap vector", TRAP_VEC_BASE + i, vec);
			chk("trap level", TRAP_LVL_TOP - i, new_lvl);
			// nesting disable still set in the first control register: keep it on
			w = 32'(1 << tbit[i]);
			if (toff[i] == OFF_CTRL1) w[BIT_NEST_DIS] = 1'b1;
			apb(0, toff[i], w, 0);
			apb(1, toff[i], w, 0);
			repeat (12) @(posedge clk);
		end
		#1 chk("irq masked", 0, irq);
		apb(1, OFF_EVT_MSK, 32'h1, 0);
		#1 chk("irq raised", 1, irq);
		apb(0, OFF_EVT, 32'h3, 0);
		apb(1, OFF_EVT, 32'h3, 0);
		#1 chk("irq cleared", 0, irq);
		finish_test();
	end
endmodule : tb_top
